/* File: src/ppfc_consts.svh */
// Purpose: constants for the port pin function block
// Assumes: AXI4-Lite byte addresses, 8-bit port fields in the low byte
// Notes: port index 0..5 = osc port, reset port, timer port, capture port, serial port, plain port
`ifndef PPFC_CONSTS_SVH
`define PPFC_CONSTS_SVH
`define PPFC_NPORT 6
`define PPFC_STRIDE 12'h020
`define PPFC_OFS_LATCH 12'h000
`define PPFC_OFS_DIR 12'h004
`define PPFC_OFS_FUNC 12'h008
`define PPFC_OFS_DRV 12'h00c
`define PPFC_OFS_PU 12'h010
`define PPFC_OFS_READ 12'h014
`define PPFC_OFS_ROUTE 12'h100
`define PPFC_OFS_RSTPIN 12'h104
`define PPFC_RSTPIN_KEY 8'h5a
`define PPFC_FUNC_RST0 8'h01
`define PPFC_ROUTE_SYNC 2'h2
`define PPFC_RESP_OK 2'h0
`define PPFC_RESP_ERR 2'h2
// implemented bits, one byte per port, port 0 in the low byte
`define PPFC_MASK_PIN 48'hff1f1fff0f0f
`define PPFC_MASK_FUNC 48'h000d031f0005
`define PPFC_MASK_DRV 48'h001f00000000
`define PPFC_MASK_PU 48'h000000000f0f
`endif

/* File: src/ppfc_pkg.sv */
// Purpose: types for the port pin function block
// Assumes: constants header alongside
// Notes: none
`include "ppfc_consts.svh"
package ppfc_pkg;
	typedef logic [`PPFC_NPORT-1:0][7:0] ppfc_bank_t;
	typedef struct packed {
		ppfc_bank_t latch;
		ppfc_bank_t dir;
		ppfc_bank_t func;
		ppfc_bank_t drv;
		ppfc_bank_t pu;
	} ppfc_cfg_t;
endpackage

/* File: src/ppfc_top.sv */
// Purpose: per-pin direction, alternate function, drive type and pull-up control
// Assumes: pad inputs synchronous to CLK; peripherals drive ALT_O
// Notes: registers over AXI4-Lite, one aligned word each
// Behaviour
// - oscillator port is four bits, each bit's direction set individually
// - oscillator port pins hand over to high and low frequency oscillators
// - each oscillator port bit has a software pull-up
// - pull-up only acts while the bit is an input
// - reset-shared pin is reset input until a reconfiguration step
// - don't-care settings do not change pin behaviour
// - selectable pins switch between open-drain and push-pull
// - settings without a register bit keep no storage
// - output mode drives latch value low or high
// - clearing oscillator input function with oscillator on raises internal reset
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ppfc_consts.svh"
module ppfc_top (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// axi4-lite slave
	input wire logic [11:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [11:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// pads
	input wire ppfc_pkg::ppfc_bank_t PAD_I,
	output ppfc_pkg::ppfc_bank_t PAD_O,
	output ppfc_pkg::ppfc_bank_t PAD_OE,
	output ppfc_pkg::ppfc_bank_t PAD_PU,
	// peripherals
	input wire ppfc_pkg::ppfc_bank_t ALT_O,
	output ppfc_pkg::ppfc_bank_t ALT_I,
	input wire logic HF_OSC_ENABLE,
	output logic HF_OSC_SEL,
	output logic LF_OSC_SEL,
	output logic EXT_RESET_EN,
	output logic CLK_FACTOR_RST,
	output logic SER_B_UART,
	output logic SER_B_SYNC
);
	import ppfc_pkg::*;

	localparam int NP = `PPFC_NPORT;
	localparam logic [47:0] PIN_MASK = `PPFC_MASK_PIN;

	function automatic logic [7:0] mask_of(input logic [47:0] m, input int p);
		mask_of = m[p*8 +: 8];
	endfunction

	// ****************************************
	// bus and register state
	// ****************************************
	ppfc_cfg_t cfg_q, cfg_d;
	logic [1:0] route_q, route_d;
	logic rst_port_q, rst_port_d;
	logic clkrst_q, clkrst_d;
	logic aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic [11:0] awaddr_q, awaddr_d;
	logic [7:0] wdata_q, wdata_d;
	logic wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	ppfc_bank_t rdback;
	logic do_wr, wr_hit;
	logic [7:0] rd_val;
	logic rd_hit;

	assign do_wr = aw_got_q & w_got_q & ~bvalid_q;

	always_comb begin
		cfg_d = cfg_q;
		route_d = route_q;
		rst_port_d = rst_port_q;
		clkrst_d = 1'b0;
		aw_got_d = aw_got_q;
		w_got_d = w_got_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q & ~BREADY;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q & ~RREADY;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		wr_hit = 1'b0;
		rd_hit = 1'b0;
		rd_val = 8'h00;
		// address and data taken in either order
		if (AWVALID & ~aw_got_q & ~bvalid_q) begin
			aw_got_d = 1'b1;
			awaddr_d = AWADDR;
		end
		if (WVALID & ~w_got_q & ~bvalid_q) begin
			w_got_d = 1'b1;
			wdata_d = WDATA[7:0];
			wstrb_d = WSTRB[0];
		end
		if (do_wr) begin
			aw_got_d = 1'b0;
			w_got_d = 1'b0;
			bvalid_d = 1'b1;
			for (int p = 0; p < NP; p++) begin
				if (awaddr_q[11:5] == 7'(p) && awaddr_q[4:0] <= 5'h10 && awaddr_q[1:0] == 2'h0) begin
					wr_hit = awaddr_q[4:2] != 3'h5;
					if (wstrb_q) begin
						case (awaddr_q[4:0])
							5'(`PPFC_OFS_LATCH): cfg_d.latch[p] = wdata_q & mask_of(`PPFC_MASK_PIN, p);
							5'(`PPFC_OFS_DIR): cfg_d.dir[p] = wdata_q & mask_of(`PPFC_MASK_PIN, p);
							// unimplemented bits stay at their reset constant
							5'(`PPFC_OFS_FUNC): cfg_d.func[p] = wdata_q & mask_of(`PPFC_MASK_FUNC, p);
							5'(`PPFC_OFS_DRV): cfg_d.drv[p] = wdata_q & mask_of(`PPFC_MASK_DRV, p);
							5'(`PPFC_OFS_PU): cfg_d.pu[p] = wdata_q & mask_of(`PPFC_MASK_PU, p);
							default: cfg_d.pu[p] = cfg_q.pu[p];
						endcase
					end
				end
			end
			if (awaddr_q == `PPFC_OFS_ROUTE) begin
				wr_hit = 1'b1;
				if (wstrb_q) route_d = wdata_q[1:0];
			end
			if (awaddr_q == `PPFC_OFS_RSTPIN) begin
				wr_hit = 1'b1;
				// key write only; no way back short of a reset
				if (wstrb_q && wdata_q == `PPFC_RSTPIN_KEY) rst_port_d = 1'b1;
			end
			// pulse on writing 0 to the hf input function while the oscillator runs
			if (awaddr_q == `PPFC_OFS_FUNC && wstrb_q && !wdata_q[0] && HF_OSC_ENABLE) begin
				clkrst_d = 1'b1;
			end
			bresp_d = wr_hit ? `PPFC_RESP_OK : `PPFC_RESP_ERR;
		end
		if (ARVALID & ~rvalid_q) begin
			for (int p = 0; p < NP; p++) begin
				if (ARADDR[11:5] == 7'(p) && ARADDR[4:0] <= 5'h14 && ARADDR[1:0] == 2'h0) begin
					rd_hit = 1'b1;
					case (ARADDR[4:2])
						3'h0: rd_val = cfg_q.latch[p];
						3'h1: rd_val = cfg_q.dir[p];
						3'h2: rd_val = cfg_q.func[p];
						3'h3: rd_val = cfg_q.drv[p];
						3'h4: rd_val = cfg_q.pu[p];
						default: rd_val = rdback[p];
					endcase
				end
			end
			if (ARADDR == `PPFC_OFS_ROUTE) begin
				rd_hit = 1'b1;
				rd_val = {6'h00, route_q};
			end
			if (ARADDR == `PPFC_OFS_RSTPIN) begin
				rd_hit = 1'b1;
				rd_val = {7'h00, rst_port_q};
			end
			rvalid_d = 1'b1;
			rdata_d = {24'h000000, rd_val};
			rresp_d = rd_hit ? `PPFC_RESP_OK : `PPFC_RESP_ERR;
		end
	end

	// ****************************************
	// pin logic
	// ****************************************
	ppfc_bank_t pad_o_d, pad_oe_d, pad_pu_d, alt_i_d;
	logic [NP*8-1:0] osc_hold;

	// osc pins are analog while selected: no digital drive, no readback
	assign osc_hold = {44'h00000000000, {2{cfg_q.func[0][2]}}, {2{cfg_q.func[0][0]}}};

	genvar gp, gb;
	generate
		for (gp = 0; gp < NP; gp++) begin : g_port
			for (gb = 0; gb < 8; gb++) begin : g_bit
				logic hold, outv;
				assign hold = osc_hold[gp*8+gb] | (gp == 1 && gb == 0 && !rst_port_q);
				// waveform reaches the pin only with both direction and function set
				assign outv = (cfg_q.dir[gp][gb] & cfg_q.func[gp][gb]) ? ALT_O[gp][gb]
					: cfg_q.latch[gp][gb];
				assign pad_o_d[gp][gb] = outv;
				// open-drain sinks only, releases the pin for a high
				assign pad_oe_d[gp][gb] = cfg_q.dir[gp][gb] & ~hold
					& ~(cfg_q.drv[gp][gb] & outv);
				assign pad_pu_d[gp][gb] = cfg_q.pu[gp][gb] & ~cfg_q.dir[gp][gb] & ~hold;
				// input side ignores the function bit
				assign alt_i_d[gp][gb] = PAD_I[gp][gb] & ~cfg_q.dir[gp][gb];
				assign rdback[gp][gb] = PAD_I[gp][gb] & ~cfg_q.dir[gp][gb] & ~hold
					& PIN_MASK[gp*8+gb];
			end
		end
	endgenerate

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cfg_q <= '0;
			cfg_q.func[0] <= `PPFC_FUNC_RST0;
			route_q <= 2'h0;
			rst_port_q <= 1'b0;
			clkrst_q <= 1'b0;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 8'h00;
			wstrb_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rresp_q <= 2'h0;
			rdata_q <= 32'h00000000;
			PAD_O <= '0;
			PAD_OE <= '0;
			PAD_PU <= '0;
			ALT_I <= '0;
			HF_OSC_SEL <= 1'b0;
			LF_OSC_SEL <= 1'b0;
			EXT_RESET_EN <= 1'b1;
			SER_B_UART <= 1'b0;
			SER_B_SYNC <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			route_q <= route_d;
			rst_port_q <= rst_port_d;
			clkrst_q <= clkrst_d;
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			PAD_O <= pad_o_d;
			PAD_OE <= pad_oe_d;
			PAD_PU <= pad_pu_d;
			ALT_I <= alt_i_d;
			HF_OSC_SEL <= cfg_q.func[0][0];
			LF_OSC_SEL <= cfg_q.func[0][2];
			EXT_RESET_EN <= ~rst_port_q;
			SER_B_UART <= ~route_q[1];
			SER_B_SYNC <= route_q == `PPFC_ROUTE_SYNC;
		end
	end

	assign AWREADY = ~aw_got_q & ~bvalid_q;
	assign WREADY = ~w_got_q & ~bvalid_q;
	assign BVALID = bvalid_q;
	assign BRESP = bresp_q;
	assign ARREADY = ~rvalid_q;
	assign RVALID = rvalid_q;
	assign RDATA = rdata_q;
	assign RRESP = rresp_q;
	assign CLK_FACTOR_RST = clkrst_q;

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);

	AST_DRIVE_LEVEL: assert property (cfg_q.dir[2][0] && !cfg_q.func[2][0] |=>
		PAD_OE[2][0] && PAD_O[2][0] == $past(cfg_q.latch[2][0])) else $error("latch not driven");
	AST_PU_INPUT: assert property (cfg_q.dir[0][3] |=> !PAD_PU[0][3])
		else $error("pull-up on output");
	AST_PU_ON: assert property (cfg_q.pu[0][3] && !cfg_q.dir[0][3] |=> PAD_PU[0][3])
		else $error("pull-up missing");
	AST_OSC_PIN: assert property (cfg_q.func[0][0] |=> !PAD_OE[0][0] && !PAD_OE[0][1] && HF_OSC_SEL)
		else $error("osc pin driven");
	AST_RST_PIN: assert property (!rst_port_q |=> !PAD_OE[1][0] && EXT_RESET_EN)
		else $error("reset pin driven");
	AST_OPEN_DRAIN: assert property (cfg_q.drv[4][1] && cfg_q.dir[4][1] && !cfg_q.func[4][1]
		&& cfg_q.latch[4][1] |=> !PAD_OE[4][1]) else $error("open drain drove high");
	AST_NO_STORE: assert property (cfg_q.func[5] == 8'h00 && cfg_q.drv[2] == 8'h00)
		else $error("storage without register");
	AST_DONT_CARE: assert property (!cfg_q.dir[3][0] |=> ALT_I[3][0] == $past(PAD_I[3][0]))
		else $error("input depends on function bit");
	AST_WAVE_OUT: assert property (cfg_q.dir[2][1] && cfg_q.func[2][1] |=>
		PAD_O[2][1] == $past(ALT_O[2][1])) else $error("waveform not on pin");
	AST_ROUTE: assert property (route_q == 2'h2 |=> SER_B_SYNC && !SER_B_UART)
		else $error("serial route wrong");
	AST_CLK_RST: assert property (do_wr && awaddr_q == 12'h008 && wstrb_q && !wdata_q[0]
		&& HF_OSC_ENABLE |=> CLK_FACTOR_RST ##1 !CLK_FACTOR_RST) else $error("no clock reset");
	AST_BHOLD: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write answer dropped");

	COV_WRITE: cover property (BVALID && BREADY);
	COV_READ: cover property (RVALID && RREADY);
	COV_CLKRST: cover property (CLK_FACTOR_RST);
	COV_PORTPIN: cover property (!EXT_RESET_EN);
endmodule
`default_nettype wire

/* File: testbench/ppfc_board.sv */
// Purpose: board and peripheral model at the pad side of the pin block
// Assumes: peripherals hold steady waveform levels
// Notes: device drive wins over the board driver
`timescale 1ns/1ps
`default_nettype none
module ppfc_board (
	// clock
	input wire logic clk,
	// device pads
	input wire ppfc_pkg::ppfc_bank_t drive_val,
	input wire ppfc_pkg::ppfc_bank_t drive_en,
	input wire ppfc_pkg::ppfc_bank_t pull_en,
	output ppfc_pkg::ppfc_bank_t pad_lvl,
	output ppfc_pkg::ppfc_bank_t periph_val,
	// board drivers
	input wire ppfc_pkg::ppfc_bank_t ext_en,
	input wire ppfc_pkg::ppfc_bank_t ext_val
);
	import ppfc_pkg::*;
	ppfc_bank_t last_q = '0;
	// ****
	// pad level
	// ****
	// floating pad flips so a stale level never passes as data
	assign pad_lvl = (drive_en & drive_val) | (~drive_en & ext_en & ext_val)
		| (~drive_en & ~ext_en & (pull_en | ~last_q));
	assign periph_val = {6{8'h3c}};
	always_ff @(posedge clk) last_q <= pad_lvl;
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Purpose: self-checking bench for the pin function block
// Assumes: register map and pin lag as handed over
// Notes: rows cover storage, hand tests cover pins
`timescale 1ns/1ps
`default_nettype none
`include "ppfc_consts.svh"
module testbench;
	import ppfc_pkg::*;
	// ****
	// signals
	// ****
	logic CLK = 1'b0, RST_B = 1'b0, HF_OSC_ENABLE = 1'b0;
	logic [11:0] AWADDR = '0, ARADDR = '0;
	logic AWVALID = 1'b0, WVALID = 1'b0, ARVALID = 1'b0, BREADY = 1'b0, RREADY = 1'b0;
	logic [31:0] WDATA = '0, RDATA, rd_v;
	logic [3:0] WSTRB = 4'h1;
	logic [1:0] BRESP, RRESP, bresp_v, rresp_v;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, cfr_v;
	logic HF_OSC_SEL, LF_OSC_SEL, EXT_RESET_EN, CLK_FACTOR_RST, SER_B_UART, SER_B_SYNC;
	ppfc_bank_t PAD_I, PAD_O, PAD_OE, PAD_PU, ALT_O, ALT_I;
	ppfc_bank_t ext_en = 48'h000000ff0000, ext_val = 48'h000000a50000;
	int error_cnt = 0, cmp_count = 0;
	// address, write byte, expected read byte
	localparam logic [27:0] ROWS [12] = '{28'h040ffff, 28'h000ff0f, 28'h004f000, 28'h048ff1f,
		28'h068ff03, 28'h088ff0d, 28'h08cff1f, 28'h04cff00, 28'h0a8ff00, 28'h0acff00,
		28'h050ff00, 28'h030ff0f};
	ppfc_top i_dut (.CLK(CLK), .RST_B(RST_B), .AWADDR(AWADDR), .AWVALID(AWVALID),
		.AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.PAD_I(PAD_I), .PAD_O(PAD_O), .PAD_OE(PAD_OE), .PAD_PU(PAD_PU), .ALT_O(ALT_O),
		.ALT_I(ALT_I), .HF_OSC_ENABLE(HF_OSC_ENABLE), .HF_OSC_SEL(HF_OSC_SEL),
		.LF_OSC_SEL(LF_OSC_SEL), .EXT_RESET_EN(EXT_RESET_EN), .CLK_FACTOR_RST(CLK_FACTOR_RST),
		.SER_B_UART(SER_B_UART), .SER_B_SYNC(SER_B_SYNC));
	ppfc_board i_board (.clk(CLK), .drive_val(PAD_O), .drive_en(PAD_OE), .pull_en(PAD_PU),
		.pad_lvl(PAD_I), .periph_val(ALT_O), .ext_en(ext_en), .ext_val(ext_val));
	// ****
	// tasks
	// ****
	// handshakes sampled mid-cycle, where the levels match the next rising edge
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic aw_t, w_t, b_t;
		b_t = 1'b0;
		@(posedge CLK);
		AWADDR <= a;
		WDATA <= {24'h0, d};
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		while (!b_t) begin
			@(negedge CLK);
			aw_t = AWVALID & AWREADY;
			w_t = WVALID & WREADY;
			b_t = BVALID;
			bresp_v = BRESP;
			cfr_v = CLK_FACTOR_RST;
			@(posedge CLK);
			if (aw_t) AWVALID <= 1'b0;
			if (w_t) WVALID <= 1'b0;
		end
		BREADY <= 1'b0;
	endtask
	task automatic wq(input logic [19:0] q[$]);
		foreach (q[k]) wr(q[k][19:8], q[k][7:0]);
	endtask
	task automatic rd(input logic [11:0] a);
		logic ar_t, r_t;
		r_t = 1'b0;
		@(posedge CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		while (!r_t) begin
			@(negedge CLK);
			ar_t = ARVALID & ARREADY;
			r_t = RVALID;
			rd_v = RDATA;
			rresp_v = RRESP;
			@(posedge CLK);
			if (ar_t) ARVALID <= 1'b0;
		end
		RREADY <= 1'b0;
	endtask
	// pins lag the register by one edge
	task automatic pins;
		@(negedge CLK);
	endtask
	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic tend(input string s);
		$display("test %s done", s);
	endtask
	task automatic do_rst;
		RST_B <= 1'b0;
		repeat (3) @(posedge CLK);
		RST_B <= 1'b1;
	endtask
	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ****
	// sequence
	// ****
	initial begin
		forever #4 CLK = ~CLK;
	end
	initial begin
		#100000;
		error_cnt++;
		close_out();
	end
	initial begin
		do_rst();
		for (int i = 0; i < 12; i++) begin
			wr(ROWS[i][27:16], ROWS[i][15:8]);
			rd(ROWS[i][27:16]);
			chk({bresp_v, rresp_v, rd_v}, {4'h0, 24'h0, ROWS[i][7:0]});
		end
		tend("rows");
		do_rst();
		repeat (3) @(negedge CLK);
		chk({HF_OSC_SEL, LF_OSC_SEL, EXT_RESET_EN}, 3'b101);
		rd(12'h008);
		chk(rd_v, 32'h01);
		rd(12'h040);
		chk(rd_v, 32'h00);
		tend("reset");
		wq('{20'h0a4ff, 20'h0a0a5, 20'h04402, 20'h04802, 20'h04002, 20'h06403, 20'h06803});
		wr(12'h060, 8'h03);
		pins();
		chk({PAD_O[5], PAD_OE[5]}, 16'ha5ff);
		chk({PAD_O[3][1:0], PAD_O[2][1], PAD_OE[3][1:0], PAD_OE[2][1]}, 6'b000111);
		wq('{20'h0841f, 20'h08c03, 20'h0801f});
		pins();
		chk(PAD_OE[4], 8'h1c);
		tend("drive");
		for (int i = 0; i < 4; i++) begin
			wr(12'h100, 8'(i));
			pins();
			chk({SER_B_UART, SER_B_SYNC}, {~i[1], i == 2});
		end
		tend("route");
		wq('{20'h0100f, 20'h0040c, 20'h00800});
		chk(cfr_v, 1'b0);
		pins();
		chk({HF_OSC_SEL, PAD_PU[0], PAD_OE[0]}, 17'h0030c);
		rd(12'h014);
		chk(rd_v, 32'h03);
		wr(12'h008, 8'h05);
		pins();
		chk({HF_OSC_SEL, LF_OSC_SEL, PAD_OE[0], PAD_PU[0]}, 18'h30000);
		rd(12'h014);
		chk(rd_v, 32'h00);
		HF_OSC_ENABLE <= 1'b1;
		wr(12'h008, 8'h04);
		chk(cfr_v, 1'b1);
		tend("osc");
		wq('{20'h02401, 20'h02001});
		pins();
		chk({EXT_RESET_EN, PAD_OE[1]}, 9'h100);
		wr(12'h104, `PPFC_RSTPIN_KEY);
		pins();
		chk({EXT_RESET_EN, PAD_OE[1]}, 9'h001);
		tend("resetpin");
		wq('{20'h04400, 20'h0481f});
		rd(12'h054);
		chk(rd_v, 32'ha5);
		wr(12'h048, 8'h00);
		rd(12'h054);
		chk(rd_v, 32'ha5);
		rd(12'h0f0);
		wr(12'h054, 8'h00);
		chk({rresp_v, bresp_v}, {`PPFC_RESP_ERR, `PPFC_RESP_ERR});
		tend("misc");
		close_out();
	end
endmodule
`default_nettype wire
